/* File: pkg/lpb_pkg.sv */
// Summary of operation
// - Slot 35 address, word count slot ignored
// - One three-cycle channel request per word
// - Two-word header; bit 0 picks format
// - Header bit 17, bits 9-16 ignored
// - Packed: five 7-bit chars per pair
// - One right-justified char per word
// - Single-line start fetches header, keeps format
// - Data words always fetched in pairs
// - Single-line: first vertical control ends, Done
// - Too many chars per line sets overflow
// - Multi-line: load count, Done at zero
// - Each non-tab control counts one line
// - Decode all listed vertical control codes
// - Tab spaces to next eight-column stop
// - Tab beyond column 128 is illegal
// - CR and escape return without paper
// - Tape-loop variant: code selects channel
// - Fixed-advance variant: fixed line counts
// - Upper-only printer folds lower case
// - Error is OR of four flags; Done
// - Busy at start, cleared with Done
// - Skip, interrupt enable, clear Done commands
// - Status read bit layout
package lpb_pkg;
  typedef logic [17:0] lpb_word_t;
  typedef logic [6:0] lpb_char_t;
  typedef logic [7:0] lpb_addr_t;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam lpb_addr_t ADDR_CMD = 8'h00;
  localparam lpb_addr_t ADDR_AC = 8'h04;
  localparam lpb_addr_t ADDR_SKIP = 8'h08;
  localparam lpb_addr_t ADDR_STATUS = 8'h0C;
  // ----------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------
  localparam lpb_word_t CMD_PRINT_SINGLE = 18'h38D61;
  localparam lpb_word_t CMD_PRINT_MULTI = 18'h38D51;
  localparam lpb_word_t CMD_SKIP = 18'h38D41;
  localparam lpb_word_t CMD_INT_EN = 18'h38D64;
  localparam lpb_word_t CMD_CLR_DONE = 18'h38D91;
  localparam lpb_word_t CMD_CLR_STATUS = 18'h38DA1;
  localparam lpb_word_t CMD_READ_STATUS = 18'h38DA2;
  // ----------------------------------------------------------
  // Channel, header and line layout
  // ----------------------------------------------------------
  localparam logic [5:0] DCH_SLOT_WC = 6'h1C;
  localparam logic [5:0] DCH_SLOT_CA = 6'h1D;
  localparam int FMT_BIT = 0;
  localparam logic [2:0] IMG_LAST = 3'h1;
  localparam logic [2:0] PACK_LAST = 3'h4;
  localparam logic [7:0] LINE_SHORT = 8'h50;
  localparam logic [7:0] LINE_LONG = 8'h84;
  localparam logic [7:0] TAB_LIMIT = 8'h80;
  // ----------------------------------------------------------
  // Character codes and paper actions
  // ----------------------------------------------------------
  localparam lpb_char_t CH_HT = 7'h09;
  localparam lpb_char_t CH_LF = 7'h0A;
  localparam lpb_char_t CH_VT = 7'h0B;
  localparam lpb_char_t CH_FF = 7'h0C;
  localparam lpb_char_t CH_CR = 7'h0D;
  localparam lpb_char_t CH_DLE = 7'h10;
  localparam lpb_char_t CH_DC1 = 7'h11;
  localparam lpb_char_t CH_DC2 = 7'h12;
  localparam lpb_char_t CH_DC3 = 7'h13;
  localparam lpb_char_t CH_DC4 = 7'h14;
  localparam lpb_char_t CH_ESC = 7'h1B;
  localparam lpb_char_t CH_SP = 7'h20;
  localparam logic [1:0] PK_RETURN = 2'h0;
  localparam logic [1:0] PK_CHANNEL = 2'h1;
  localparam logic [1:0] PK_LINES = 2'h2;
  localparam logic [1:0] PK_TOP = 2'h3;
  typedef enum logic [2:0] {
    LPB_IDLE = 3'b000,
    LPB_HDR = 3'b001,
    LPB_FETCH = 3'b010,
    LPB_CHAR = 3'b011,
    LPB_PRINT = 3'b100,
    LPB_TAB = 3'b101,
    LPB_PAPER = 3'b110,
    LPB_FINISH = 3'b111
  } lpb_state_e;
endpackage

/* File: pkg/lpb_upk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lpb_upk_if;
  import lpb_pkg::*;
  lpb_word_t w0;
  lpb_word_t w1;
  logic fmt;
  logic [2:0] idx;
  lpb_char_t chr;
  logic last;
  modport ctl (output w0, w1, fmt, idx, input chr, last);
  modport upk (input w0, w1, fmt, idx, output chr, last);
endinterface
`default_nettype wire

/* File: src/lpb_unpack.sv */
`timescale 1ns/1ps
`default_nettype none
module lpb_unpack (
  // Word pair and character position
  lpb_upk_if.upk bus
);
  import lpb_pkg::*;
  logic [35:0] pair;
  logic [35:0] shifted;
  assign pair = {bus.w0, bus.w1};
  assign shifted = pair << (6'(bus.idx) * 6'h07);
  assign bus.chr = bus.fmt ? (bus.idx[0] ? bus.w1[6:0] : bus.w0[6:0]) : shifted[35:29];
  assign bus.last = bus.fmt ? (bus.idx == IMG_LAST) : (bus.idx == PACK_LAST);
endmodule
`default_nettype wire

/* File: src/lpb_ctrl.sv */
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lpb_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire lpb_pkg::lpb_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data channel
  output logic dch_req,
  output logic [5:0] dch_slot,
  input wire logic dch_ack,
  input wire lpb_pkg::lpb_word_t dch_data,
  // Character path
  output logic pr_valid,
  output lpb_pkg::lpb_char_t pr_data,
  input wire logic pr_ready,
  // Paper motion
  output logic pp_valid,
  output logic [1:0] pp_kind,
  output logic [4:0] pp_arg,
  input wire logic paper_ack,
  // Printer condition and configuration
  input wire logic printer_fault,
  input wire logic printer_connected,
  input wire logic tape_unit_present,
  input wire logic wide_line,
  input wire logic upper_only,
  // Host attention
  output logic int_req
);
  import lpb_pkg::*;

  typedef struct packed {
    lpb_state_e st;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    lpb_word_t ac;
    logic skip;
    logic ie;
    logic done;
    logic busy;
    logic ovf;
    logic illtab;
    logic multi;
    logic fmt;
    lpb_word_t w0;
    lpb_word_t w1;
    logic wsel;
    logic [2:0] idx;
    logic [7:0] col;
    logic [8:0] lcnt;
    logic dch_req;
    logic [5:0] dch_slot;
    logic pr_valid;
    lpb_char_t pr_data;
    logic pp_valid;
    logic [1:0] pp_kind;
    logic [4:0] pp_arg;
    logic int_req;
  } lpb_state_s;

  lpb_state_s s;
  lpb_state_s next_s;
  lpb_upk_if upk ();

  // ----------------------------------------------------------
  // Character decoding
  // ----------------------------------------------------------
  function automatic logic is_vert(input lpb_char_t c);
    return (c == CH_LF) || (c == CH_VT) || (c == CH_FF) || (c == CH_CR) ||
           (c == CH_ESC) || ((c >= CH_DLE) && (c <= CH_DC4));
  endfunction

  function automatic logic [6:0] paper_cmd(input lpb_char_t c, input logic tape_unit);
    logic [6:0] r;
    r = {PK_RETURN, 5'h00};
    if (tape_unit) begin
      unique case (c)
        CH_LF: r = {PK_CHANNEL, 5'h08};
        CH_VT: r = {PK_CHANNEL, 5'h07};
        CH_FF: r = {PK_CHANNEL, 5'h01};
        CH_DLE: r = {PK_CHANNEL, 5'h02};
        CH_DC1: r = {PK_CHANNEL, 5'h03};
        CH_DC2: r = {PK_CHANNEL, 5'h04};
        CH_DC3: r = {PK_CHANNEL, 5'h05};
        CH_DC4: r = {PK_CHANNEL, 5'h06};
        default: r = {PK_RETURN, 5'h00};
      endcase
    end else begin
      unique case (c)
        CH_LF: r = {PK_LINES, 5'h01};
        CH_VT: r = {PK_LINES, 5'h14};
        CH_FF: r = {PK_TOP, 5'h00};
        CH_DLE: r = {PK_LINES, 5'h1E};
        CH_DC1: r = {PK_LINES, 5'h02};
        CH_DC2: r = {PK_LINES, 5'h03};
        CH_DC3: r = {PK_LINES, 5'h01};
        CH_DC4: r = {PK_LINES, 5'h0A};
        default: r = {PK_RETURN, 5'h00};
      endcase
    end
    return r;
  endfunction

  // Step to the next character, or fetch the next pair when used up
  function automatic logic [3:0] advance(input logic [2:0] idx, input logic last);
    return last ? 4'h8 : {1'b0, 3'(idx + 3'h1)};
  endfunction

  // ----------------------------------------------------------
  // Unpacker and derived terms
  // ----------------------------------------------------------
  assign upk.w0 = s.w0;
  assign upk.w1 = s.w1;
  assign upk.fmt = s.fmt;
  assign upk.idx = s.idx;

  lpb_unpack u_unpack (
    .bus(upk)
  );

  logic alarm;
  logic ilock;
  logic err;
  logic [7:0] line_len;
  lpb_char_t chr;
  lpb_word_t status_word;
  logic [3:0] adv;
  logic acc;

  assign alarm = printer_fault;
  assign ilock = !printer_connected;
  assign err = alarm | s.ovf | s.illtab | ilock;
  assign line_len = wide_line ? LINE_LONG : LINE_SHORT;
  assign chr = (upper_only && upk.chr >= 7'h61 && upk.chr <= 7'h7A) ? 7'(upk.chr - 7'h20) : upk.chr;
  assign status_word = {err, alarm, s.ovf, s.illtab, s.busy, s.done, ilock, 11'h000};
  assign adv = advance(s.idx, upk.last);
  assign acc = psel & penable;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.dch_slot = DCH_SLOT_CA;
    if (acc && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        ADDR_CMD: next_s.prdata = 32'h0000_0000;
        ADDR_AC: next_s.prdata = {14'h0000, s.ac};
        ADDR_SKIP: next_s.prdata = {31'h0000_0000, s.skip};
        ADDR_STATUS: next_s.prdata = {14'h0000, status_word};
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (acc && s.pready && pwrite && paddr == ADDR_CMD) begin
      case (pwdata[17:0])
        CMD_PRINT_SINGLE, CMD_PRINT_MULTI: begin
          if (!s.busy) begin
            next_s.busy = 1'b1;
            next_s.done = 1'b0;
            next_s.multi = (pwdata[17:0] == CMD_PRINT_MULTI);
            next_s.st = LPB_HDR;
            next_s.dch_req = 1'b1;
            next_s.wsel = 1'b0;
            next_s.col = 8'h00;
          end
        end
        CMD_SKIP: next_s.skip = s.done | err;
        CMD_INT_EN: next_s.ie = 1'b1;
        CMD_CLR_DONE: next_s.done = 1'b0;
        CMD_READ_STATUS: next_s.ac = status_word;
        CMD_CLR_STATUS: begin
          next_s.ovf = 1'b0;
          next_s.illtab = 1'b0;
        end
        default: next_s.ac = s.ac;
      endcase
    end
    unique case (s.st)
      LPB_IDLE: begin
        next_s.dch_req = next_s.dch_req;
      end
      LPB_HDR: begin
        if (dch_ack) begin
          if (!s.wsel) begin
            // Only the format bit of the first word is kept
            next_s.fmt = dch_data[FMT_BIT];
            next_s.wsel = 1'b1;
          end else begin
            if (s.multi) begin
              next_s.lcnt = {(dch_data[7:0] == 8'h00), dch_data[7:0]};
            end
            next_s.wsel = 1'b0;
            next_s.st = LPB_FETCH;
          end
        end
      end
      LPB_FETCH: begin
        if (dch_ack) begin
          if (!s.wsel) begin
            next_s.w0 = dch_data;
            next_s.wsel = 1'b1;
          end else begin
            next_s.w1 = dch_data;
            next_s.wsel = 1'b0;
            next_s.dch_req = 1'b0;
            next_s.idx = 3'h0;
            next_s.st = LPB_CHAR;
          end
        end
      end
      LPB_CHAR: begin
        if (chr == CH_HT) begin
          if (s.col > TAB_LIMIT) begin
            next_s.illtab = 1'b1;
            next_s.st = LPB_FINISH;
          end else begin
            next_s.pr_valid = 1'b1;
            next_s.pr_data = CH_SP;
            next_s.st = LPB_TAB;
          end
        end else if (is_vert(chr)) begin
          next_s.pp_valid = 1'b1;
          {next_s.pp_kind, next_s.pp_arg} = paper_cmd(chr, tape_unit_present);
          next_s.st = LPB_PAPER;
        end else if (s.col >= line_len) begin
          next_s.ovf = 1'b1;
          next_s.st = LPB_FINISH;
        end else begin
          next_s.pr_valid = 1'b1;
          next_s.pr_data = chr;
          next_s.st = LPB_PRINT;
        end
      end
      LPB_PRINT: begin
        if (pr_ready) begin
          next_s.pr_valid = 1'b0;
          next_s.col = 8'(s.col + 8'h01);
          next_s.idx = adv[2:0];
          next_s.st = adv[3] ? LPB_FETCH : LPB_CHAR;
          next_s.dch_req = adv[3];
        end
      end
      LPB_TAB: begin
        if (pr_ready) begin
          next_s.col = 8'(s.col + 8'h01);
          if (s.col[2:0] == 3'h7) begin
            next_s.pr_valid = 1'b0;
            next_s.idx = adv[2:0];
            next_s.st = adv[3] ? LPB_FETCH : LPB_CHAR;
            next_s.dch_req = adv[3];
          end
        end
      end
      LPB_PAPER: begin
        if (paper_ack) begin
          next_s.pp_valid = 1'b0;
          next_s.col = 8'h00;
          if (s.multi) begin
            next_s.lcnt = 9'(s.lcnt - 9'h001);
          end
          if (s.multi && s.lcnt != 9'h001) begin
            next_s.idx = adv[2:0];
            next_s.st = adv[3] ? LPB_FETCH : LPB_CHAR;
            next_s.dch_req = adv[3];
          end else begin
            next_s.st = LPB_FINISH;
          end
        end
      end
      LPB_FINISH: begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.dch_req = 1'b0;
        next_s.pr_valid = 1'b0;
        next_s.pp_valid = 1'b0;
        next_s.st = LPB_IDLE;
      end
    endcase
    // Printer trouble stops the operation after what was already taken
    if ((alarm || ilock) && s.st != LPB_IDLE && s.st != LPB_FINISH) begin
      next_s.st = LPB_FINISH;
    end
    next_s.int_req = s.ie & (s.done | err);
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign dch_req = s.dch_req;
  assign dch_slot = s.dch_slot;
  assign pr_valid = s.pr_valid;
  assign pr_data = s.pr_data;
  assign pp_valid = s.pp_valid;
  assign pp_kind = s.pp_kind;
  assign pp_arg = s.pp_arg;
  assign int_req = s.int_req;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  AST_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
    s.dch_req |-> s.dch_slot == DCH_SLOT_CA)
    else $error("channel request not on the address slot");

  AST_START_FETCH: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.busy) |-> s.dch_req && s.st == LPB_HDR)
    else $error("start did not request the header");

  AST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.ovf) |-> $past(s.col) >= $past(line_len) && s.st == LPB_FINISH)
    else $error("overflow raised below line length");

  AST_TAB_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == LPB_TAB && pr_ready && s.col[2:0] == 3'h7 |=> s.st != LPB_TAB && s.col[2:0] == 3'h0)
    else $error("tab did not stop at the column stop");

  AST_ILLTAB: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.illtab) |-> $past(s.col) > TAB_LIMIT)
    else $error("illegal tab below column limit");

  AST_DONE_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.done) |-> !s.busy && $past(s.st) == LPB_FINISH)
    else $error("done raised while busy");

  AST_COL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == LPB_PAPER && paper_ack |=> s.col == 8'h00 && !s.pp_valid)
    else $error("column not reset after line end");

  AST_LCNT: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == LPB_PAPER && paper_ack && s.multi |=> s.lcnt == 9'($past(s.lcnt) - 9'h001))
    else $error("line counter not decremented");

  AST_SINGLE_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == LPB_PAPER && paper_ack && !s.multi |=> s.st == LPB_FINISH ##1 s.done)
    else $error("single line did not finish");

  AST_TAB_NOCOUNT: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == LPB_TAB |=> s.lcnt == $past(s.lcnt))
    else $error("tab changed the line counter");
endmodule
`default_nettype wire

/* File: bench/lpb_chan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpb_chan_model #(
  parameter int GAP = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data channel
  input wire logic dch_req,
  input wire logic [5:0] dch_slot,
  output logic dch_ack,
  output lpb_pkg::lpb_word_t dch_data
);
  import lpb_pkg::*;
  lpb_word_t mem [0:127];
  int ca = 0;
  int wait_n;
  // Current address is bumped before each word; the count slot is never read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dch_ack <= 1'b0;
      dch_data <= 18'h2AAAA;
      wait_n <= 0;
    end else begin
      dch_ack <= 1'b0;
      // Data is only valid with the ack; scramble it otherwise
      dch_data <= ~dch_data;
      if (dch_req && !dch_ack && dch_slot == DCH_SLOT_CA) begin
        if (wait_n >= GAP) begin
          ca <= ca + 1;
          dch_data <= mem[(ca + 1) % 128];
          dch_ack <= 1'b1;
          wait_n <= 0;
        end else begin
          wait_n <= wait_n + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/lpb_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lpb_ctrl_tb;
  import lpb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  lpb_addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dch_req, dch_ack, pr_valid, pp_valid, int_req;
  logic [5:0] dch_slot;
  lpb_word_t dch_data;
  lpb_char_t pr_data;
  logic [1:0] pp_kind;
  logic [4:0] pp_arg;
  logic pr_ready = 1'b0;
  logic paper_ack = 1'b0;
  logic printer_fault = 1'b0;
  logic printer_connected = 1'b1;
  logic tape_unit_present = 1'b0;
  logic wide_line = 1'b1;
  logic upper_only = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  lpb_char_t got_c[$];
  logic [6:0] got_p[$];
  lpb_word_t wq[$];

  always #12.5 pclk = ~pclk;

  lpb_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dch_req(dch_req), .dch_slot(dch_slot), .dch_ack(dch_ack), .dch_data(dch_data),
    .pr_valid(pr_valid), .pr_data(pr_data), .pr_ready(pr_ready), .pp_valid(pp_valid),
    .pp_kind(pp_kind), .pp_arg(pp_arg), .paper_ack(paper_ack), .printer_fault(printer_fault),
    .printer_connected(printer_connected), .tape_unit_present(tape_unit_present), .wide_line(wide_line),
    .upper_only(upper_only), .int_req(int_req));

  lpb_chan_model #(.GAP(3)) mdl_u (.pclk(pclk), .presetn(presetn), .dch_req(dch_req),
    .dch_slot(dch_slot), .dch_ack(dch_ack), .dch_data(dch_data));

  // Printer stalls every other cycle; paper motion acknowledged once
  always @(posedge pclk) begin
    pr_ready <= ~pr_ready;
    paper_ack <= pp_valid && !paper_ack;
    if (pr_valid && pr_ready) got_c.push_back(pr_data);
    if (pp_valid && paper_ack) got_p.push_back({pp_kind, pp_arg});
  end

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input lpb_addr_t a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input lpb_addr_t a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic cmd(input lpb_word_t c);
    logic [31:0] q;
    logic e;
    apb(1'b1, ADDR_CMD, {14'h0, c}, q, e);
  endtask

  task automatic st(output logic [31:0] q);
    rd(ADDR_STATUS, q);
    q = q & 32'h3F800;
  endtask

  task automatic go(input lpb_word_t code, input logic fmt, input logic [7:0] cnt, input lpb_char_t cs[$]);
    logic [35:0] b;
    logic [31:0] s;
    int k;
    wq = '{{1'b1, 8'h00, 8'hFF, fmt}, {10'h000, cnt}};
    if (fmt) begin
      foreach (cs[i]) wq.push_back({11'h000, cs[i]});
      if (cs.size() % 2) wq.push_back(18'h0);
    end else begin
      for (int i = 0; i < cs.size(); i += 5) begin
        b = '0;
        for (int j = 0; j < 5; j++) if (i + j < cs.size()) b[35 - 7 * j -: 7] = cs[i + j];
        wq.push_back(b[35:18]);
        wq.push_back(b[17:0]);
      end
    end
    foreach (wq[i]) mdl_u.mem[i + 1] = wq[i];
    mdl_u.ca = 0;
    got_c = {};
    got_p = {};
    cmd(code);
    st(s);
    chk(s[13], 1'b1);
    k = 0;
    do begin
      st(s);
      k++;
    end while (s[12] !== 1'b1 && k < 500);
    if (k >= 500) n_errors++;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic s_image;
    logic [31:0] s;
    upper_only <= 1'b1;
    go(CMD_PRINT_SINGLE, 1'b1, 8'h05, '{7'h61, 7'h42, CH_LF, 7'h5A});
    chk(got_c.size(), 2);
    chk({got_c[0], got_c[1]}, {7'h41, 7'h42});
    chk(got_p[0], {PK_LINES, 5'h01});
    st(s);
    chk(s, 32'h01000);
    chk(int_req, 1'b0);
    cmd(CMD_SKIP);
    rd(ADDR_SKIP, s);
    chk(s[0], 1'b1);
    cmd(CMD_CLR_DONE);
    st(s);
    chk(s, 32'h0);
    upper_only <= 1'b0;
  endtask

  task automatic s_packed;
    tape_unit_present <= 1'b1;
    go(CMD_PRINT_MULTI, 1'b0, 8'h03, '{7'h48, 7'h69, CH_CR, 7'h78, CH_ESC, CH_LF, 7'h51});
    chk(got_c.size(), 3);
    chk({got_c[0], got_c[1], got_c[2]}, {7'h48, 7'h69, 7'h78});
    chk(got_p.size(), 3);
    chk(got_p[0][6:5], PK_RETURN);
    chk(got_p[1], {PK_RETURN, 5'h00});
    chk(got_p[2], {PK_CHANNEL, 5'h08});
  endtask

  task automatic s_vctl;
    lpb_char_t cs[$] = '{CH_LF, CH_VT, CH_FF, CH_DLE, CH_DC1, CH_DC2, CH_DC3, CH_DC4};
    logic [4:0] fx [8] = '{5'h01, 5'h14, 5'h00, 5'h1E, 5'h02, 5'h03, 5'h01, 5'h0A};
    logic [4:0] tp [8] = '{5'h08, 5'h07, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06};
    for (int v = 0; v < 2; v++) begin
      tape_unit_present <= v[0];
      go(CMD_PRINT_MULTI, 1'b1, 8'h08, cs);
      chk(got_p.size(), 8);
      chk(got_c.size(), 0);
      for (int i = 0; i < 8; i++) begin
        if (v == 1) chk(got_p[i], {PK_CHANNEL, tp[i]});
        else if (i == 2) chk(got_p[i][6:5], PK_TOP);
        else chk(got_p[i], {PK_LINES, fx[i]});
      end
    end
  endtask

  task automatic s_tab;
    logic [31:0] s;
    lpb_char_t cs[$];
    go(CMD_PRINT_SINGLE, 1'b1, 8'h01, '{7'h41, CH_HT, 7'h42, CH_LF});
    chk(got_c.size(), 9);
    chk({got_c[1], got_c[7], got_c[8]}, {CH_SP, CH_SP, 7'h42});
    repeat (129) cs.push_back(7'h78);
    cs.push_back(CH_HT);
    cs.push_back(CH_LF);
    go(CMD_PRINT_SINGLE, 1'b0, 8'h01, cs);
    st(s);
    chk(s[17:14], 4'h9);
    cmd(CMD_CLR_STATUS);
    wide_line <= 1'b0;
    cs = {};
    repeat (81) cs.push_back(7'h78);
    cs.push_back(CH_LF);
    go(CMD_PRINT_SINGLE, 1'b0, 8'h01, cs);
    st(s);
    chk(s[17:15], 3'h5);
    cmd(CMD_CLR_STATUS);
    st(s);
    chk(s[15:14], 2'h0);
    wide_line <= 1'b1;
  endtask

  task automatic s_fault;
    logic [31:0] s;
    logic e;
    chk(dch_slot, DCH_SLOT_CA);
    printer_fault <= 1'b1;
    cmd(CMD_INT_EN);
    st(s);
    chk(s[17:16], 2'h3);
    cmd(CMD_SKIP);
    rd(ADDR_SKIP, s);
    chk(s[0], 1'b1);
    chk(int_req, 1'b1);
    printer_fault <= 1'b0;
    printer_connected <= 1'b0;
    cmd(CMD_READ_STATUS);
    rd(ADDR_AC, s);
    chk({s[17], s[11]}, 2'h3);
    printer_connected <= 1'b1;
    apb(1'b0, 8'h10, 32'h0, s, e);
    chk({e, s[0]}, 2'h2);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_image();
    s_packed();
    s_vctl();
    s_tab();
    s_fault();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
